// file: hw/sac_params.svh
// constants of the slot access-assignment codec
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define SAC_ADDR_CTRL     8'h00
`define SAC_ADDR_CFG_NORM 8'h04
`define SAC_ADDR_CFG_F18  8'h08
`define SAC_ADDR_TRAFFIC  8'h0C
`define SAC_ADDR_STATUS   8'h10
`define SAC_ADDR_DECODE   8'h14
// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define SAC_CFG_HDR_LSB   16
`define SAC_CFG_F1_LSB    8
`define SAC_CFG_F2_LSB    0
`define SAC_ST_FRAME_LSB  16
`define SAC_ST_SLOT_LSB   24
`define SAC_ST_MKERR_BIT  28
`define SAC_ST_TREF_BIT   29
// ---------------------------------------------------------------------
// header and marker codes
// ---------------------------------------------------------------------
`define SAC_HDR_00        2'h0
`define SAC_HDR_01        2'h1
`define SAC_HDR_10        2'h2
`define SAC_HDR_11        2'h3
`define SAC_MK_RESERVED   6'h03
`define SAC_MK_COMMON     6'h02
`define SAC_MK_ASSIGNED   6'h01
`define SAC_MK_UNALLOC    6'h00
// ---------------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------------
`define SAC_TRAFFIC_RST   6'h04
`define SAC_SLOT_LAST     2'h3
`define SAC_FRAME_FIRST   5'h01
`define SAC_FRAME_LAST    5'h12
`define SAC_SLOT_CYCLES   1024
`endif

// file: hw/sac_pkg.sv
// types and marker decoding shared by the codec files
package sac_pkg;
`include "sac_params.svh"
   typedef enum logic [2:0] {MK_ACCESS, MK_RESERVED, MK_COMMON,
                             MK_ASSIGNED, MK_UNALLOC, MK_TRAFFIC} sac_marker_e;
   typedef enum logic [1:0] {UL_COMMON_ONLY, UL_COMMON_ASSIGNED,
                             UL_ASSIGNED_ONLY, UL_BY_MARKER} sac_rights_e;
   typedef struct packed {
      logic [15:0] divCnt;
      logic [1:0]  slot;
      logic [4:0]  frame;
      logic        is18;
      logic        tick;
   } sac_timer_s;
   typedef struct packed {
      logic        enable;
      logic [1:0]  hdrN;
      logic [5:0]  f1N;
      logic [5:0]  f2N;
      logic [1:0]  hdrE;
      logic [5:0]  f1E;
      logic [5:0]  f2E;
      logic [5:0]  traffic;
      logic [13:0] word;
      logic        wordIs18;
      logic        valid;
      logic        markerErr;
      logic        trafRefused;
      logic [31:0] prdata;
   } sac_core_s;
   // downlink marker class
   function automatic sac_marker_e sac_dl_class(input logic [5:0] m);
      unique case (m)
         `SAC_MK_RESERVED: return MK_RESERVED;
         `SAC_MK_COMMON:   return MK_COMMON;
         `SAC_MK_ASSIGNED: return MK_ASSIGNED;
         `SAC_MK_UNALLOC:  return MK_UNALLOC;
         default:          return MK_TRAFFIC;
      endcase
   endfunction
   // uplink marker class
   function automatic sac_marker_e sac_ul_class(input logic [5:0] m);
      return (m == `SAC_MK_UNALLOC) ? MK_UNALLOC : MK_TRAFFIC;
   endfunction
endpackage

// file: hw/sac_frame_timer.sv
// slot and frame counter giving one tick per downlink slot
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_frame_timer #(
   parameter int unsigned SLOT_CYCLES = `SAC_SLOT_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       enable,
   output logic            slotTick,
   output logic [1:0]      slotNum,
   output logic [4:0]      frameNum,
   output logic            frameIs18
);
   localparam logic [15:0] DIV_LAST = 16'(SLOT_CYCLES - 1);
   sac_pkg::sac_timer_s timer_reg;
   sac_pkg::sac_timer_s timer_next;

   // ---------------------------------------------------------------
   // counting
   // ---------------------------------------------------------------
   // [RQ17] one shared frame count
   always_comb begin
      timer_next = timer_reg;
      timer_next.tick = 1'b0;
      if (!enable) begin
         timer_next.divCnt = 16'h0000;  // restart the slot on enable
      end else if (timer_reg.divCnt == DIV_LAST) begin
         timer_next.divCnt = 16'h0000;
         timer_next.tick = 1'b1;
         timer_next.slot = timer_reg.slot + 2'h1;
         if (timer_reg.slot == `SAC_SLOT_LAST) begin
            timer_next.frame = (timer_reg.frame == `SAC_FRAME_LAST) ?
                               `SAC_FRAME_FIRST : timer_reg.frame + 5'h01;
         end
         timer_next.is18 = (timer_next.frame == `SAC_FRAME_LAST);
      end else begin
         timer_next.divCnt = timer_reg.divCnt + 16'h0001;
      end
   end

   // first tick lands on slot 0 of frame 1
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_reg <= '{divCnt: 16'h0000, slot: `SAC_SLOT_LAST,
                        frame: `SAC_FRAME_LAST, is18: 1'b1, tick: 1'b0};
      end else begin
         timer_reg <= timer_next;
      end
   end

   assign slotTick  = timer_reg.tick;
   assign slotNum   = timer_reg.slot;
   assign frameNum  = timer_reg.frame;
   assign frameIs18 = timer_reg.is18;
endmodule

// file: hw/sac_word_parser.sv
// mobile-side reading of one access-assignment word
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_word_parser (
   input  wire logic [13:0]         word,
   input  wire logic                isFrame18,
   output sac_pkg::sac_rights_e     rights,
   output sac_pkg::sac_marker_e     dlUse,
   output sac_pkg::sac_marker_e     ulUse,
   output logic                     af1Valid,
   output logic                     af2Valid,
   output logic                     afBothValid
);
   logic [1:0] hdr;
   logic [5:0] f1;
   logic [5:0] f2;
   assign hdr = word[13:12];
   assign f1  = word[11:6];
   assign f2  = word[5:0];

   // ---------------------------------------------------------------
   // interpretation by header and frame type
   // ---------------------------------------------------------------
   // [RQ5] header and frame pick meaning
   always_comb begin
      rights = sac_pkg::UL_COMMON_ONLY;
      dlUse = sac_pkg::MK_ACCESS;
      ulUse = sac_pkg::MK_ACCESS;
      af1Valid = 1'b0;
      af2Valid = 1'b0;
      afBothValid = 1'b0;
      // [RQ4] frame 18 has own table
      if (isFrame18) begin
         // [RQ14] split access fields
         unique case (hdr)
            `SAC_HDR_00: rights = sac_pkg::UL_COMMON_ONLY;
            `SAC_HDR_01: rights = sac_pkg::UL_COMMON_ASSIGNED;
            `SAC_HDR_10: rights = sac_pkg::UL_ASSIGNED_ONLY;
            `SAC_HDR_11: rights = sac_pkg::UL_COMMON_ASSIGNED;
         endcase
         // [RQ15] traffic marker plus shared field
         if (hdr == `SAC_HDR_11) begin
            dlUse = sac_pkg::MK_TRAFFIC;
            afBothValid = 1'b1;
         end else begin
            af1Valid = 1'b1;
            af2Valid = 1'b1;
         end
      end else begin
         // [RQ10] downlink marker classes
         dlUse = sac_pkg::sac_dl_class(f1);
         unique case (hdr)
            // [RQ6] common control, split fields
            `SAC_HDR_00: begin
               dlUse = sac_pkg::MK_COMMON;
               af1Valid = 1'b1;
               af2Valid = 1'b1;
            end
            // [RQ7] common and assigned
            `SAC_HDR_01: begin
               rights = sac_pkg::UL_COMMON_ASSIGNED;
               afBothValid = 1'b1;
            end
            // [RQ8] assigned only
            `SAC_HDR_10: begin
               rights = sac_pkg::UL_ASSIGNED_ONLY;
               afBothValid = 1'b1;
            end
            // [RQ11] uplink marker in field two
            `SAC_HDR_11: begin
               rights = sac_pkg::UL_BY_MARKER;
               ulUse = sac_pkg::sac_ul_class(f2);
            end
         endcase
      end
   end
endmodule

// file: hw/sac_codec.sv
// base-station access-assignment word builder with apb registers
// What this block does
// [RQ1] word built in mac, no payload
// [RQ2] one word on every downlink slot
// [RQ3] word covers same-numbered downlink and uplink slot
// [RQ4] frames 1-17 and 18 use different tables
// [RQ5] 2-bit header then two 6-bit fields
// [RQ6] normal header 00: common, two access fields
// [RQ7] normal header 01: marker, shared access field
// [RQ8] normal header 10: assigned only, same layout
// [RQ9] normal header 11: downlink and uplink markers
// [RQ10] downlink marker codes reserved, common, assigned, free
// [RQ11] uplink marker zero free, else traffic
// [RQ12] preset codes never used as traffic marker
// [RQ13] numbered fields per subslot, plain covers both
// [RQ14] frame 18 headers 00-10: two access fields
// [RQ15] frame 18 header 11: traffic marker, shared field
// [RQ16] access field: 2-bit code, 4-bit length
// [RQ17] frame number from shared frame counter
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_codec #(
   parameter int unsigned SLOT_CYCLES = `SAC_SLOT_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [13:0]      bcastWord,
   output logic             bcastValid,
   output logic [1:0]       slotNum,
   output logic [4:0]       frameNum
);
   sac_pkg::sac_core_s   core_reg;
   sac_pkg::sac_core_s   core_next;
   logic                 slotTick;
   logic                 frameIs18;
   logic [1:0]           selHdr;
   logic [5:0]           selF1;
   logic [5:0]           selF2;
   logic                 mapped;
   logic                 setup;
   logic                 wrAcc;
   logic [31:0]          rdMux;
   sac_pkg::sac_rights_e rights;
   sac_pkg::sac_marker_e dlUse;
   sac_pkg::sac_marker_e ulUse;
   logic                 af1Valid;
   logic                 af2Valid;
   logic                 afBothValid;

   // ---------------------------------------------------------------
   // slot timing and readback parser
   // ---------------------------------------------------------------
   sac_frame_timer #(.SLOT_CYCLES(SLOT_CYCLES)) u_timer (
      .clk       (clk),
      .rst_b     (rst_b),
      .enable    (core_reg.enable),
      .slotTick  (slotTick),
      .slotNum   (slotNum),
      .frameNum  (frameNum),
      .frameIs18 (frameIs18)
   );

   // parses the word last sent so software sees the mobile view
   sac_word_parser u_parser (
      .word        (core_reg.word),
      .isFrame18   (core_reg.wordIs18),
      .rights      (rights),
      .dlUse       (dlUse),
      .ulUse       (ulUse),
      .af1Valid    (af1Valid),
      .af2Valid    (af2Valid),
      .afBothValid (afBothValid)
   );

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // zero wait states; misaligned or unknown offsets answer an error
   assign setup = psel & ~penable;
   assign wrAcc = psel & penable & pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign mapped = (paddr == `SAC_ADDR_CTRL) ||
                   (paddr == `SAC_ADDR_CFG_NORM) ||
                   (paddr == `SAC_ADDR_CFG_F18) ||
                   (paddr == `SAC_ADDR_TRAFFIC) ||
                   (paddr == `SAC_ADDR_STATUS) ||
                   (paddr == `SAC_ADDR_DECODE);

   // read data, reserved bits zero
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (paddr)
         `SAC_ADDR_CTRL: rdMux[0] = core_reg.enable;
         `SAC_ADDR_CFG_NORM: begin
            rdMux[`SAC_CFG_HDR_LSB +: 2] = core_reg.hdrN;
            rdMux[`SAC_CFG_F1_LSB +: 6] = core_reg.f1N;
            rdMux[`SAC_CFG_F2_LSB +: 6] = core_reg.f2N;
         end
         `SAC_ADDR_CFG_F18: begin
            rdMux[`SAC_CFG_HDR_LSB +: 2] = core_reg.hdrE;
            rdMux[`SAC_CFG_F1_LSB +: 6] = core_reg.f1E;
            rdMux[`SAC_CFG_F2_LSB +: 6] = core_reg.f2E;
         end
         `SAC_ADDR_TRAFFIC: rdMux[5:0] = core_reg.traffic;
         `SAC_ADDR_STATUS: begin
            rdMux[13:0] = core_reg.word;
            rdMux[14] = core_reg.wordIs18;
            rdMux[`SAC_ST_FRAME_LSB +: 5] = frameNum;
            rdMux[`SAC_ST_SLOT_LSB +: 2] = slotNum;
            rdMux[`SAC_ST_MKERR_BIT] = core_reg.markerErr;
            rdMux[`SAC_ST_TREF_BIT] = core_reg.trafRefused;
         end
         // [RQ13] subslot coverage shown to software
         `SAC_ADDR_DECODE: begin
            rdMux[1:0] = rights;
            rdMux[6:4] = dlUse;
            rdMux[10:8] = ulUse;
            rdMux[12] = af1Valid;
            rdMux[13] = af2Valid;
            rdMux[14] = afBothValid;
         end
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // [RQ4] table chosen by frame type
   assign selHdr = frameIs18 ? core_reg.hdrE : core_reg.hdrN;
   assign selF1  = frameIs18 ? core_reg.f1E : core_reg.f1N;
   assign selF2  = frameIs18 ? core_reg.f2E : core_reg.f2N;

   // ---------------------------------------------------------------
   // registers and word building
   // ---------------------------------------------------------------
   always_comb begin
      logic [5:0] f1;
      logic [5:0] f2;
      logic       err;
      f1 = selF1;
      f2 = selF2;
      err = 1'b0;
      core_next = core_reg;
      core_next.valid = 1'b0;
      if (setup && !pwrite) begin
         core_next.prdata = rdMux;  // latched in setup, shown in access
      end
      if (wrAcc) begin
         unique case (paddr)
            `SAC_ADDR_CTRL: core_next.enable = pwdata[0];
            `SAC_ADDR_CFG_NORM: begin
               core_next.hdrN = pwdata[`SAC_CFG_HDR_LSB +: 2];
               core_next.f1N = pwdata[`SAC_CFG_F1_LSB +: 6];
               core_next.f2N = pwdata[`SAC_CFG_F2_LSB +: 6];
            end
            `SAC_ADDR_CFG_F18: begin
               core_next.hdrE = pwdata[`SAC_CFG_HDR_LSB +: 2];
               core_next.f1E = pwdata[`SAC_CFG_F1_LSB +: 6];
               core_next.f2E = pwdata[`SAC_CFG_F2_LSB +: 6];
            end
            // [RQ12] preset codes refused
            `SAC_ADDR_TRAFFIC: begin
               if (sac_pkg::sac_dl_class(pwdata[5:0]) ==
                   sac_pkg::MK_TRAFFIC) begin
                  core_next.traffic = pwdata[5:0];
               end else begin
                  core_next.trafRefused = 1'b1;
               end
            end
            // write one to clear the sticky flags
            `SAC_ADDR_STATUS: begin
               if (pwdata[`SAC_ST_MKERR_BIT]) begin
                  core_next.markerErr = 1'b0;
               end
               if (pwdata[`SAC_ST_TREF_BIT]) begin
                  core_next.trafRefused = 1'b0;
               end
            end
            default: core_next.enable = core_reg.enable;
         endcase
      end
      // [RQ2] one word per slot tick
      if (slotTick) begin
         if (frameIs18) begin
            // [RQ15] frame 18 traffic marker
            if (selHdr == `SAC_HDR_11) begin
               f1 = core_reg.traffic;
            end
         end else if (selHdr != `SAC_HDR_00) begin
            // [RQ10] no reserved or foreign marker
            if (sac_pkg::sac_dl_class(f1) == sac_pkg::MK_RESERVED ||
                (sac_pkg::sac_dl_class(f1) == sac_pkg::MK_TRAFFIC &&
                 f1 != core_reg.traffic)) begin
               f1 = `SAC_MK_UNALLOC;
               err = 1'b1;
            end
            // [RQ9] uplink marker free or traffic
            if (selHdr == `SAC_HDR_11 && f2 != `SAC_MK_UNALLOC &&
                f2 != core_reg.traffic) begin
               f2 = `SAC_MK_UNALLOC;
               err = 1'b1;
            end
         end
         // [RQ5] header then field one, field two
         // [RQ16] access fields kept whole, code over length
         core_next.word = {selHdr, f1, f2};
         core_next.wordIs18 = frameIs18;
         core_next.valid = 1'b1;
      end
      // set wins over a clear in the same cycle
      if (err) begin
         core_next.markerErr = 1'b1;
      end
   end

   // [RQ1] word holds mac fields only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_reg <= '{traffic: `SAC_TRAFFIC_RST, default: '0};
      end else begin
         core_reg <= core_next;
      end
   end

   // [RQ3] word belongs to the current slot number
   assign bcastWord  = core_reg.word;
   assign bcastValid = core_reg.valid;
   assign prdata     = core_reg.prdata;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_tick_word;
      @(posedge clk) disable iff (!rst_b) slotTick |=> bcastValid;
   endproperty
   a_tick_word: assert property (p_tick_word) // [RQ2]
      else $error("slot tick without broadcast word");

   property p_no_spurious;
      @(posedge clk) disable iff (!rst_b)
         bcastValid |-> $past(slotTick) && !slotTick;
   endproperty
   a_no_spurious: assert property (p_no_spurious) // [RQ2]
      else $error("broadcast word without slot tick");

   property p_header_select;
      @(posedge clk) disable iff (!rst_b)
         bcastValid |-> bcastWord[13:12] ==
            ($past(frameIs18) ? $past(core_reg.hdrE) : $past(core_reg.hdrN));
   endproperty
   a_header_select: assert property (p_header_select) // [RQ4]
      else $error("header not taken from the frame's table");

   property p_split_fields;
      @(posedge clk) disable iff (!rst_b)
         bcastValid && bcastWord[13:12] == `SAC_HDR_00 |->
            bcastWord[11:0] == ($past(frameIs18) ?
               {$past(core_reg.f1E), $past(core_reg.f2E)} :
               {$past(core_reg.f1N), $past(core_reg.f2N)})
            && af1Valid && af2Valid && !afBothValid;
   endproperty
   a_split_fields: assert property (p_split_fields) // [RQ6]
      else $error("header 00 access fields altered");

   property p_f18_traffic;
      @(posedge clk) disable iff (!rst_b)
         bcastValid && core_reg.wordIs18 &&
         bcastWord[13:12] == `SAC_HDR_11 |->
            bcastWord[11:6] == $past(core_reg.traffic) && afBothValid;
   endproperty
   a_f18_traffic: assert property (p_f18_traffic) // [RQ15]
      else $error("frame 18 header 11 lacks traffic marker");

   property p_dl_marker;
      @(posedge clk) disable iff (!rst_b)
         bcastValid && !core_reg.wordIs18 &&
         bcastWord[13:12] != `SAC_HDR_00 |->
            bcastWord[11:6] != `SAC_MK_RESERVED &&
            (bcastWord[11:6] <= `SAC_MK_RESERVED ||
             bcastWord[11:6] == $past(core_reg.traffic));
   endproperty
   a_dl_marker: assert property (p_dl_marker) // [RQ10]
      else $error("illegal downlink usage marker sent");

   property p_ul_marker;
      @(posedge clk) disable iff (!rst_b)
         bcastValid && !core_reg.wordIs18 &&
         bcastWord[13:12] == `SAC_HDR_11 |->
            bcastWord[5:0] == `SAC_MK_UNALLOC ||
            bcastWord[5:0] == $past(core_reg.traffic);
   endproperty
   a_ul_marker: assert property (p_ul_marker) // [RQ11]
      else $error("illegal uplink usage marker sent");

   property p_traffic_code;
      @(posedge clk) disable iff (!rst_b)
         wrAcc && paddr == `SAC_ADDR_TRAFFIC &&
         pwdata[5:0] <= `SAC_MK_RESERVED |=>
            core_reg.trafRefused && $stable(core_reg.traffic) &&
            core_reg.traffic > `SAC_MK_RESERVED;
   endproperty
   a_traffic_code: assert property (p_traffic_code) // [RQ12]
      else $error("preset code accepted as traffic marker");

   property p_frame_wrap;
      @(posedge clk) disable iff (!rst_b)
         // checked on the wrapping tick itself, so any slot length works
         slotTick && $past(frameNum) == `SAC_FRAME_LAST &&
         $past(slotNum) == `SAC_SLOT_LAST |->
            frameNum == `SAC_FRAME_FIRST && slotNum == 2'h0 && !frameIs18;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) // [RQ17]
      else $error("frame counter did not wrap after frame 18");
endmodule

// file: verification/sac_mobile_model.sv
// mobile-side model that listens to the downlink word
`timescale 1ns/1ps
module sac_mobile_model (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [13:0] word,
   input  wire logic        valid,
   input  wire logic [4:0]  frameNum,
   output logic [15:0]      wordCnt,
   output logic             shared
);
   // ---------------------------------------------------------------
   // capture each word as it is announced
   // ---------------------------------------------------------------
   // one word per slot
   // header and frame pick the layout
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wordCnt <= 16'h0000;
         shared  <= 1'b0;
      end else if (valid) begin
         wordCnt <= wordCnt + 16'h0001;
         // frame 18 shares the field only under header 11
         shared  <= (frameNum == 5'h12) ? (word[13:12] == 2'h3) :
                    (word[13:12] == 2'h1 || word[13:12] == 2'h2);
      end
   end
endmodule

// file: verification/sac_codec_bench.sv
// self-checking bench for the access-assignment word builder
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_codec_bench;
   localparam int unsigned SC = 8;
   logic        clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [13:0] bcastWord;
   logic        bcastValid;
   logic [1:0]  slotNum;
   logic [4:0]  frameNum;
   logic [15:0] mobCnt;
   logic        mobShared;
   logic [31:0] rd;
   logic        err;
   int          mismatches;
   int          nTests;
   sac_codec #(.SLOT_CYCLES(SC)) dut (.clk(clk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bcastWord(bcastWord), .bcastValid(bcastValid),
      .slotNum(slotNum), .frameNum(frameNum));
   sac_mobile_model mob (.clk(clk), .rst_b(rst_b), .word(bcastWord),
      .valid(bcastValid), .frameNum(frameNum), .wordCnt(mobCnt),
      .shared(mobShared));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic test_done();
      $display("mismatches %0d of %0d checks", mismatches, nTests);
      if (mismatches == 0 && nTests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      nTests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %h", $time, msg, got);
      end
   endtask
   // one apb transfer; result lands in rd and err
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         mismatches++;
         test_done();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait for the next announced word
   task automatic wait_word();
      int n;
      n = 0;
      // sampled mid-cycle, away from the edge that launches the word
      do begin
         @(negedge clk);
         n++;
      end while (bcastValid !== 1'b1 && n < 4 * SC);
      if (bcastValid !== 1'b1) begin
         mismatches++;
         test_done();
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, `SAC_ADDR_TRAFFIC, 32'h0000_0000);
      chk(rd, 32'h0000_0004, "traffic reset");
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001, "unmapped error");
      chk(rd, 32'h0000_0000, "unmapped data");
      // preset codes refused as traffic marker
      apb(1'b1, `SAC_ADDR_TRAFFIC, 32'h0000_0002);
      apb(1'b0, `SAC_ADDR_TRAFFIC, 32'h0000_0000);
      chk(rd, 32'h0000_0004, "preset kept out");
      apb(1'b0, `SAC_ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, rd[29]}, 32'h0000_0001, "refuse flag");
      apb(1'b1, `SAC_ADDR_TRAFFIC, 32'h0000_0025);
      apb(1'b0, `SAC_ADDR_TRAFFIC, 32'h0000_0000);
      chk(rd, 32'h0000_0025, "traffic accepted");
   endtask
   // a full multiframe: order of slots, frame 18 swap of tables
   task automatic t_walk();
      logic [13:0] exp;
      apb(1'b1, `SAC_ADDR_CFG_NORM, 32'h0000_152A);
      apb(1'b1, `SAC_ADDR_CFG_F18, 32'h0003_001B);
      apb(1'b1, `SAC_ADDR_CTRL, 32'h0000_0001);
      for (int i = 0; i < 72; i++) begin
         wait_word();
         exp = (i / 4 == 17) ? {2'h3, 6'h25, 6'h1B} :
                               {2'h0, 6'h15, 6'h2A};
         chk(bcastWord, exp, "word");
         chk(slotNum, i % 4, "slot");
         chk(frameNum, i / 4 + 1, "frame");
         @(negedge clk);
         chk(mobShared, i / 4 == 17, "field sharing");
      end
      apb(1'b1, `SAC_ADDR_CTRL, 32'h0000_0000);
      chk(mobCnt, 72, "one word per slot");
   endtask
   // header 11: bad uplink marker replaced, decode of markers
   task automatic t_marks();
      apb(1'b1, `SAC_ADDR_CFG_NORM, 32'h0003_2507);
      apb(1'b1, `SAC_ADDR_CTRL, 32'h0000_0001);
      wait_word();
      chk(bcastWord, {2'h3, 6'h25, 6'h00}, "marker word");
      chk(frameNum, 1, "frame wraps");
      apb(1'b1, `SAC_ADDR_CTRL, 32'h0000_0000);
      apb(1'b0, `SAC_ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, rd[28]}, 32'h0000_0001, "marker flag");
      apb(1'b0, `SAC_ADDR_DECODE, 32'h0000_0000);
      chk(rd, 32'h0000_0453, "decode");
      apb(1'b1, `SAC_ADDR_STATUS, 32'h1000_0000);
      apb(1'b0, `SAC_ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, rd[28]}, 32'h0000_0000, "flag cleared");
   endtask
   // headers 01 and 10: reserved marker dropped, assigned one kept
   task automatic t_hdrs();
      apb(1'b1, `SAC_ADDR_CFG_NORM, 32'h0001_0311);
      apb(1'b1, `SAC_ADDR_CTRL, 32'h0000_0001);
      wait_word();
      chk(bcastWord, {2'h1, 6'h00, 6'h11}, "reserved dropped");
      apb(1'b1, `SAC_ADDR_CFG_NORM, 32'h0002_0111);
      wait_word();
      chk(bcastWord, {2'h2, 6'h01, 6'h11}, "assigned kept");
      apb(1'b1, `SAC_ADDR_CTRL, 32'h0000_0000);
      apb(1'b0, `SAC_ADDR_DECODE, 32'h0000_0000);
      chk(rd, 32'h0000_4032, "shared field decode");
   endtask
   // ---------------------------------------------------------------
   // clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hard cut if any path hangs
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end
   initial begin
      mismatches = 0;
      nTests     = 0;
      rst_b      = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0000_0000;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_walk();
      t_marks();
      t_hdrs();
      test_done();
   end
endmodule
